// [rtl/dbgsec_pkg.sv]
`default_nettype none
package dbgsec_pkg;
    // Debug unit resources
    localparam int NUM_BKPT = 4;
    localparam int NUM_WATCH = 2;
    localparam int ADDR_W = 32;
    // Oscillator trim codes in MHz steps
    localparam logic [5:0] OSC_DEFAULT_MHZ = 6'h18;
    localparam logic [5:0] OSC_FLASH_MHZ = 6'h30;
    // Supervisory ROM size in bytes
    localparam int SUP_ROM_BYTES = 8192;
    localparam int SUP_ROM_AW = 13;
    // Flash row time
    localparam int CLK_MHZ = 40;
    localparam int ROW_TIME_MS = 20;
    localparam int ROW_CYCLES = ROW_TIME_MS * 1000 * CLK_MHZ;
    localparam int ROW_CNT_W = 20;
    // Flash operation states
    typedef enum logic [2:0]
    {
        FL_IDLE = 3'b001,
        FL_BUSY = 3'b010,
        FL_DONE = 3'b100
    } dbgsec_fl_state_t;
endpackage
`default_nettype wire

// [rtl/dbgsec_ctrl.sv]
// Notes on behaviour
// - Debug enabled straight out of reset.
// - Only firmware can disable debug.
// - Re-enable needs erase, unprotect, enabling firmware.
// - Security lock permanently kills all interfaces.
// - Two-wire port only echoes data XOR clock; comparators load over cmp_wr while granted.
// - Four breakpoint and two watchpoint comparators.
// - Flash operations force oscillator to 48 MHz.
// - Flash routines live in supervisory ROM.
`timescale 1ns/10ps
`default_nettype none
module dbgsec_ctrl #(
    parameter int ROW_CYCLES = dbgsec_pkg::ROW_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Firmware controls
    input wire logic fw_debug_off,
    input wire logic fw_debug_on,
    input wire logic fw_secure_lock,
    input wire logic [5:0] fw_osc_mhz,
    // Probe recovery status and requests
    input wire logic probe_full_erase,
    input wire logic probe_prot_cleared,
    input wire logic probe_req,
    // Serial-wire pins from outside
    input wire logic swd_clk_pin,
    input wire logic swd_io_in,
    output logic swd_io_out,
    output logic swd_io_oe,
    input wire logic swd_io_drive,
    // Comparator setup and core bus
    input wire logic cmp_wr,
    input wire logic [2:0] cmp_sel,
    input wire logic [31:0] cmp_val,
    input wire logic [31:0] core_addr,
    input wire logic [31:0] core_data,
    output logic bkpt_hit,
    output logic watch_hit,
    // Flash through supervisory call
    input wire logic supervisory_call,
    input wire logic [12:0] supervisory_rom_addr,
    output logic flash_busy,
    output logic [5:0] main_internal_oscillator,
    // Status
    output logic debug_enabled,
    output logic secure_locked,
    output logic probe_grant,
    output logic [12:0] supervisory_rom_entry
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
logic [1:0] clk_s_r, clk_s_nxt, io_s_r, io_s_nxt;
always_comb
begin
    clk_s_nxt = {clk_s_r[0], swd_clk_pin};
    io_s_nxt = {io_s_r[0], swd_io_in};
end
always_ff @(posedge ref_clk)
begin
    if (reset)
    begin
        clk_s_r <= 2'h0;
        io_s_r <= 2'h0;
    end
    else
    begin
        clk_s_r <= clk_s_nxt;
        io_s_r <= io_s_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Debug enable and security lock
logic dbg_en_r, dbg_en_nxt, lock_r, lock_nxt;
logic erased_r, erased_nxt, unprot_r, unprot_nxt;
always_comb
begin
    lock_nxt = lock_r | fw_secure_lock;
    erased_nxt = erased_r;
    unprot_nxt = unprot_r;
    dbg_en_nxt = dbg_en_r;
    if (!dbg_en_r && !lock_r)
    begin
        erased_nxt = erased_r | probe_full_erase;
        unprot_nxt = unprot_r | (erased_r & probe_prot_cleared);
        if (fw_debug_on && unprot_r)
        begin
            dbg_en_nxt = 1'b1;
            erased_nxt = 1'b0;
            unprot_nxt = 1'b0;
        end
    end
    if (fw_debug_off)
        dbg_en_nxt = 1'b0;
    if (lock_nxt)
        dbg_en_nxt = 1'b0;
end
always_ff @(posedge ref_clk)
begin
    if (reset)
    begin
        dbg_en_r <= 1'b1;
        lock_r <= 1'b0;
        erased_r <= 1'b0;
        unprot_r <= 1'b0;
    end
    else
    begin
        dbg_en_r <= dbg_en_nxt;
        lock_r <= lock_nxt;
        erased_r <= erased_nxt;
        unprot_r <= unprot_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Probe gating and two-wire data
logic grant_r, grant_nxt, io_o_r, io_o_nxt, oe_r, oe_nxt;
always_comb
begin
    // Gate with the next enable so access drops on the same edge as debug
    grant_nxt = probe_req & dbg_en_nxt & ~lock_nxt;
    oe_nxt = swd_io_drive & dbg_en_nxt & ~lock_nxt;
    io_o_nxt = oe_nxt ? (io_s_r[1] ^ clk_s_r[1]) : 1'b0;
end
always_ff @(posedge ref_clk)
begin
    if (reset)
    begin
        grant_r <= 1'b0;
        oe_r <= 1'b0;
        io_o_r <= 1'b0;
    end
    else
    begin
        grant_r <= grant_nxt;
        oe_r <= oe_nxt;
        io_o_r <= io_o_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Breakpoint and watchpoint comparators
localparam int NCMP = dbgsec_pkg::NUM_BKPT + dbgsec_pkg::NUM_WATCH;
logic [31:0] cmp_r [NCMP];
logic [NCMP-1:0] match;
genvar gi;
generate
    for (gi = 0; gi < NCMP; gi++)
    begin : g_cmp
        always_ff @(posedge ref_clk)
        begin
            if (reset)
                cmp_r[gi] <= 32'h0;
            else if (cmp_wr && grant_r && cmp_sel == 3'(gi))
                cmp_r[gi] <= cmp_val;
        end
        if (gi < dbgsec_pkg::NUM_BKPT)
        begin : g_b
            assign match[gi] = (core_addr == cmp_r[gi]);
        end
        else
        begin : g_w
            assign match[gi] = (core_data == cmp_r[gi]);
        end
    end
endgenerate
logic bk_r, bk_nxt, wt_r, wt_nxt;
always_comb
begin
    bk_nxt = dbg_en_r & ~lock_r & (|match[dbgsec_pkg::NUM_BKPT-1:0]);
    wt_nxt = dbg_en_r & ~lock_r & (|match[NCMP-1:dbgsec_pkg::NUM_BKPT]);
end
always_ff @(posedge ref_clk)
begin
    if (reset)
    begin
        bk_r <= 1'b0;
        wt_r <= 1'b0;
    end
    else
    begin
        bk_r <= bk_nxt;
        wt_r <= wt_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Flash operation and oscillator override
dbgsec_pkg::dbgsec_fl_state_t fl_r, fl_nxt;
logic [dbgsec_pkg::ROW_CNT_W-1:0] cnt_r, cnt_nxt;
logic [12:0] entry_r, entry_nxt;
logic [5:0] osc_r, osc_nxt;
always_comb
begin
    fl_nxt = fl_r;
    cnt_nxt = cnt_r;
    entry_nxt = entry_r;
    case (fl_r)
        dbgsec_pkg::FL_IDLE:
            if (supervisory_call)
            begin
                fl_nxt = dbgsec_pkg::FL_BUSY;
                entry_nxt = supervisory_rom_addr;
                cnt_nxt = '0;
            end
        dbgsec_pkg::FL_BUSY:
            if (cnt_r == dbgsec_pkg::ROW_CNT_W'(ROW_CYCLES - 1))
                fl_nxt = dbgsec_pkg::FL_DONE;
            else
                cnt_nxt = cnt_r + {{(dbgsec_pkg::ROW_CNT_W-1){1'b0}}, 1'b1};
        dbgsec_pkg::FL_DONE:
            fl_nxt = dbgsec_pkg::FL_IDLE;
        default:
            fl_nxt = dbgsec_pkg::FL_IDLE;
    endcase
    osc_nxt = (fl_nxt == dbgsec_pkg::FL_BUSY) ? dbgsec_pkg::OSC_FLASH_MHZ : fw_osc_mhz;
end
always_ff @(posedge ref_clk)
begin
    if (reset)
    begin
        fl_r <= dbgsec_pkg::FL_IDLE;
        cnt_r <= '0;
        entry_r <= 13'h0;
        osc_r <= dbgsec_pkg::OSC_DEFAULT_MHZ;
    end
    else
    begin
        fl_r <= fl_nxt;
        cnt_r <= cnt_nxt;
        entry_r <= entry_nxt;
        osc_r <= osc_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Outputs
assign swd_io_out = io_o_r;
assign swd_io_oe = oe_r;
assign bkpt_hit = bk_r;
assign watch_hit = wt_r;
assign flash_busy = (fl_r == dbgsec_pkg::FL_BUSY);
assign main_internal_oscillator = osc_r;
assign debug_enabled = dbg_en_r;
assign secure_locked = lock_r;
assign probe_grant = grant_r;
assign supervisory_rom_entry = entry_r;

////////////////////////////////////////////////////////////////////////
// Assertions
a_reset_dbg_on: assert property (@(posedge ref_clk) $fell(reset) |-> debug_enabled)
    else $error("debug not enabled after reset");
a_lock_sticky: assert property (@(posedge ref_clk) disable iff (reset) secure_locked |=> secure_locked)
    else $error("lock released");
a_lock_kills: assert property (@(posedge ref_clk) disable iff (reset) secure_locked |-> !debug_enabled && !swd_io_oe)
    else $error("interface alive while locked");
a_fw_off: assert property (@(posedge ref_clk) disable iff (reset) fw_debug_off |=> !debug_enabled)
    else $error("firmware disable ignored");
a_reenable_path: assert property (@(posedge ref_clk) disable iff (reset)
    !debug_enabled ##1 debug_enabled |-> $past(unprot_r, 1))
    else $error("debug re-enabled without recovery");
a_no_grant_off: assert property (@(posedge ref_clk) disable iff (reset) !debug_enabled |-> !probe_grant)
    else $error("grant while disabled");
a_osc_flash: assert property (@(posedge ref_clk) disable iff (reset)
    flash_busy |-> main_internal_oscillator == dbgsec_pkg::OSC_FLASH_MHZ)
    else $error("oscillator not forced during flash");
a_supcall_start: assert property (@(posedge ref_clk) disable iff (reset)
    supervisory_call && fl_r == dbgsec_pkg::FL_IDLE |=> flash_busy && supervisory_rom_entry == $past(supervisory_rom_addr))
    else $error("supervisory call not started");
a_bkpt_gate: assert property (@(posedge ref_clk) disable iff (reset) bkpt_hit |-> $past(debug_enabled))
    else $error("breakpoint while disabled");
a_oe_gate: assert property (@(posedge ref_clk) disable iff (reset) !debug_enabled |-> !swd_io_oe)
    else $error("port drives while disabled");
a_watch_gate: assert property (@(posedge ref_clk) disable iff (reset) watch_hit |-> $past(debug_enabled))
    else $error("watchpoint while disabled");
endmodule
`default_nettype wire

// [verif/dbgsec_probe_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dbgsec_probe_model (
    // Clock
    input wire logic ref_clk,
    // Recovery and access
    output logic probe_full_erase,
    output logic probe_prot_cleared,
    output logic probe_req,
    // Two-wire port
    output logic swd_clk_pin,
    output logic swd_io_in,
    output logic swd_io_drive,
    input wire logic swd_io_out,
    input wire logic swd_io_oe
);
    // Link clock stands still, no frames are sent
    initial
    begin
        probe_full_erase = 1'h0;
        probe_prot_cleared = 1'h0;
        probe_req = 1'h0;
        swd_clk_pin = 1'h0;
        swd_io_drive = 1'h0;
    end
    // Released line shows the inverse of its last value, starting high
    always @(negedge ref_clk) swd_io_in <= (swd_io_oe === 1'b1) ? swd_io_out : (swd_io_in !== 1'b1);
    task automatic ask(input logic on);
        probe_req = on;
        swd_io_drive = on;
    endtask
    // Erase strictly before unprotect, a cycle apart
    task automatic recover();
        @(negedge ref_clk);
        probe_full_erase = 1;
        @(negedge ref_clk);
        probe_full_erase = 0;
        probe_prot_cleared = 1;
        @(negedge ref_clk);
        probe_prot_cleared = 0;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int ROW = 20;
    logic ref_clk = 0, reset = 1, fw_debug_off = 0, fw_debug_on = 0, fw_secure_lock = 0;
    logic [5:0] fw_osc_mhz = 6'h18, main_internal_oscillator, e_osc = 6'h18;
    logic probe_full_erase, probe_prot_cleared, probe_req, swd_clk_pin, swd_io_in;
    logic swd_io_out, swd_io_oe, swd_io_drive, cmp_wr = 0, bkpt_hit, watch_hit;
    logic [2:0] cmp_sel = 3'h0;
    logic [31:0] cmp_val = 32'h0, core_addr = 32'h1, core_data = 32'h1;
    logic supervisory_call = 0, flash_busy, debug_enabled, secure_locked, probe_grant;
    logic [12:0] supervisory_rom_addr = 13'h0, supervisory_rom_entry, e_ent = 13'h0;
    logic e_en = 1, e_lk = 0, e_gr = 0, e_bz = 0, e_bk = 0, e_wh = 0;
    int unsigned cyc = 0, n;
    logic [31:0] ign_val = 32'h1;
    logic [26:0] e_st, s_st;
    int bad_count = 0, checked = 0;
    int unsigned due_q[$];
    logic [26:0] exp_q[$];
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    dbgsec_ctrl #(.ROW_CYCLES(ROW)) u_dbgsec_ctrl (.*);
    dbgsec_probe_model u_dbgsec_probe_model (.*);
    ////////////////////////////////////////
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Status is compared one cycle after its note was taken
    always @(negedge ref_clk)
    begin
        while (due_q.size() != 0 && due_q[0] < cyc)
        begin
            void'(due_q.pop_front());
            e_st = exp_q.pop_front();
            s_st = {debug_enabled, secure_locked, probe_grant, swd_io_oe, swd_io_out & ~swd_io_oe, flash_busy,
                bkpt_hit, watch_hit, main_internal_oscillator, supervisory_rom_entry};
            cmp("status", 32'(e_st), 32'(s_st));
        end
    end
    task automatic quiet();
        @(negedge ref_clk);
        core_addr = $urandom | 32'h1;
        core_data = $urandom | 32'h1;
        e_bk = 0;
        e_wh = 0;
    endtask
    task automatic tick();
        due_q.push_back(cyc);
        // Port drives exactly when granted; data stays low while released
        exp_q.push_back({e_en, e_lk, e_gr, e_gr, 1'h0, e_bz, e_bk, e_wh, e_osc, e_ent});
        quiet();
    endtask
    task automatic try_cmp(input logic on);
        for (int s = 0; s < 6; s++)
        begin
            cmp_wr = 1;
            cmp_sel = s[2:0];
            cmp_val = $urandom & 32'hfffffffe;
            if (!on && s == 0)
                ign_val = cmp_val;
            quiet();
            cmp_wr = 0;
            if (s < 4)
                core_addr = cmp_val;
            else
                core_data = cmp_val;
            e_bk = on && s < 4;
            e_wh = on && s > 3;
            tick();
        end
    endtask
    task automatic print_verdict();
        // Notes never matched with a result count against the run
        bad_count += exp_q.size();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        void'($urandom(59516));
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'h0;
        begin : scenarios
            tick();
            u_dbgsec_probe_model.ask(1'h1);
            e_gr = 1'h1;
            tick();
            try_cmp(1'h1);
            supervisory_call = 1'h1;
            supervisory_rom_addr = 13'($urandom);
            fw_osc_mhz = 6'h20;
            e_bz = 1'h1;
            e_osc = 6'h30;
            e_ent = supervisory_rom_addr;
            tick();
            supervisory_call = 1'h0;
            for (n = 0; n < 100 && flash_busy === 1'b1; n++)
                quiet();
            // A hung flash operation goes straight to the report
            if (n == 100)
            begin
                bad_count++;
                disable scenarios;
            end
            cmp("busy cycles", ROW, n);
            e_bz = 1'h0;
            e_osc = fw_osc_mhz;
            tick();
            // Off and on together: off must win
            fw_debug_off = 1'h1;
            fw_debug_on = 1'h1;
            quiet();
            fw_debug_off = 1'h0;
            fw_debug_on = 1'h0;
            e_en = 1'h0;
            e_gr = 1'h0;
            tick();
            try_cmp(1'h0);
            fw_debug_on = 1'h1;
            quiet();
            fw_debug_on = 1'h0;
            tick();
            u_dbgsec_probe_model.recover();
            fw_debug_on = 1'h1;
            quiet();
            fw_debug_on = 1'h0;
            e_en = 1'h1;
            e_gr = 1'h1;
            tick();
            // A comparator written while disabled must still hold its old value
            core_addr = ign_val;
            tick();
            fw_secure_lock = 1'h1;
            quiet();
            fw_secure_lock = 1'h0;
            e_lk = 1'h1;
            e_en = 1'h0;
            e_gr = 1'h0;
            tick();
            u_dbgsec_probe_model.recover();
            fw_debug_on = 1'h1;
            quiet();
            fw_debug_on = 1'h0;
            try_cmp(1'h0);
        end
        repeat (2) @(negedge ref_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
